//--- src/pca_defs.svh
// Register indices, field positions, reset values and counts of the counter array
`ifndef PCA_DEFS_SVH
`define PCA_DEFS_SVH

// Register indices; byte address on the bus is four times the index
`define IDX_CTRL        8'hD8
`define IDX_MODE_BASE   8'hDA
`define IDX_CAPL_BASE   8'hEA
`define IDX_CAPH_BASE   8'hFA
`define IDX_CNT_LO      8'hE9
`define IDX_CNT_HI      8'hF9

// Module mode register fields
`define MODE_IRQ_EN     0
`define MODE_PWM        1
`define MODE_FLIP       2
`define MODE_HIT        3
`define MODE_CAP_FALL   4
`define MODE_CAP_RISE   5
`define MODE_CMP_EN     6
`define MODE_RSVD       7

// Counter control register fields
`define CTRL_RUN        6

// Reset values
`define MODE_RESET      8'h00
`define CNT_RESET       8'h00
`define CAP_RESET       8'h00
`define CTRL_RESET      8'h00

// Default counter prescale, in mclk cycles per count
`define DIV_DEFAULT     6
// Number of compare/capture modules
`define MODULES_DEFAULT 5

`endif

//--- src/pca_pkg.sv
// Types shared by the counter array files
package pca_pkg;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

  // One register byte
  typedef logic [7:0] reg_byte_t;

  // Counter and compare word
  typedef logic [15:0] count_t;

endpackage

//--- src/module_channel.sv
// One compare/capture module: match, edge capture, toggle and pulse-width output
`timescale 1ns/10ps
module module_channel (
  input  wire logic            mclk,
  input  wire logic            srst,
  input  wire pca_pkg::count_t count,
  input  wire pca_pkg::count_t cmp,
  input  wire logic            count_upd,
  input  wire logic            compare_enable,
  input  wire logic            capture_rise_enable,
  input  wire logic            capture_fall_enable,
  input  wire logic            hit_flag_enable,
  input  wire logic            flip_on_hit_enable,
  input  wire logic            pulse_width_enable,
  input  wire logic            pin_i,
  output logic                 match_evt,
  output logic                 capture_evt,
  output logic                 pin_o,
  output logic                 pin_oe_n
);
  import pca_pkg::*;

  logic pin_prev_q;  // Pin level one cycle ago
  logic pin_prev_d;
  logic out_q;       // Output pin level
  logic out_d;
  logic oe_n_q;      // Registered output enable, low drives
  logic oe_n_d;
  logic equal;       // Counter equals compare, on a fresh count

  // Next values for edge history and output pin
  always_comb begin
    pin_prev_d = pin_i;
    // Only a freshly advanced or written count can match, so a stopped
    // counter does not flag forever
    equal       = count_upd && (count == cmp);
    match_evt   = compare_enable && hit_flag_enable && equal;
    capture_evt = (capture_rise_enable && pin_i && !pin_prev_q) ||
                  (capture_fall_enable && !pin_i && pin_prev_q);
    out_d = out_q;
    if (compare_enable && pulse_width_enable) begin
      // Low while low count byte is below the compare low byte
      out_d = (count[7:0] >= cmp[7:0]);
    end else if (compare_enable && hit_flag_enable && flip_on_hit_enable && equal) begin
      out_d = !out_q;
    end
    // Pin is driven only in an output mode
    oe_n_d = !(compare_enable && (pulse_width_enable || flip_on_hit_enable));
  end

  // Register stage
  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_prev_q <= 1'b0;
      out_q      <= 1'b0;
      oe_n_q     <= 1'b1;
    end else begin
      pin_prev_q <= pin_prev_d;
      out_q      <= out_d;
      oe_n_q     <= oe_n_d;
    end
  end

  assign pin_o    = out_q;
  assign pin_oe_n = oe_n_q;

endmodule

//--- src/counter_array_module_mode.sv
// Counter array: shared 16-bit counter, module mode registers, Wishbone slave
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/10ps
`include "pca_defs.svh"

// Overview of the block
// - One shared 16-bit up counter, split into a low and a high byte
// - Up to five compare/capture modules, each with its own mode byte
// - Each module owns a 16-bit compare/capture word, low and high byte
// - One control byte: run bit and one event flag per module
// - One interrupt request line, the OR of enabled module flags
//
// Counter timing
// - The counter advances once per prescale tick while run is set
// - The tick is a one-cycle enable from a divider, never a second clock
// - A software write to either counter byte wins over a tick
// - Reading both bytes takes two accesses; the pair is not atomic
// - Software must stop the counter for a coherent 16-bit read
//
// Match timing
// - Only a freshly changed count can match
// - A stopped counter therefore flags once, not every cycle
// - Flag sets at the edge after the fresh count is seen
// - A toggling pin inverts at that same edge
//
// Capture timing
// - Pin levels are taken as already synchronous to mclk
// - Edges come from the pin against its level one cycle earlier
// - A capture overwrites the compare word, so capture and compare
//   on the same module fight; software picks one use per module
//
// Bus timing
// - Every access is answered one cycle after it is first seen
// - Only the low byte lane carries register data
// - Unmapped places read zero and ignore writes, but still answer

module counter_array_module_mode #(
  parameter int MODULES = `MODULES_DEFAULT, // Compare/capture modules
  parameter int DIV     = `DIV_DEFAULT      // mclk cycles per count
) (
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire logic [9:0]           wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic                 wb_we_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  output logic                      wb_ack_o,
  input  wire logic [MODULES-1:0]   module_io_pin_i,
  output logic [MODULES-1:0]        module_io_pin_o,
  output logic [MODULES-1:0]        module_io_pin_oe_n,
  output logic                      irq_request_o
);
  import pca_pkg::*;

  // Refuse shapes the control register cannot hold
  initial begin
    if (MODULES < 1 || MODULES > 5) begin
      $error("MODULES must be 1 to 5");
    end
    if (DIV < 1 || DIV > 255) begin
      $error("DIV must be 1 to 255");
    end
  end

  localparam logic [7:0] DIV_LAST = 8'(DIV - 1); // Last prescale count

  // ---------------- Bus slave state ----------------
  bus_state_t  bus_q;      // Slave state
  bus_state_t  bus_d;
  logic [31:0] rdat_q;     // Read data, shown with ack
  logic [31:0] rdat_d;
  logic [7:0]  idx;        // Register index from byte address
  logic        req;        // Live request
  logic        wr_now;     // Write takes effect this edge
  logic [7:0]  wbyte;      // Low byte lane of write data

  // ---------------- Counter state ----------------
  logic [7:0]  pre_q;      // Prescaler count
  logic [7:0]  pre_d;
  reg_byte_t   cnt_lo_q;   // Counter low byte
  reg_byte_t   cnt_lo_d;
  reg_byte_t   cnt_hi_q;   // Counter high byte
  reg_byte_t   cnt_hi_d;
  logic        upd_q;      // Counter changed last edge
  logic        upd_d;
  logic        run_q;      // Counter run control
  logic        run_d;
  logic        tick;       // One-cycle count enable
  count_t      count;      // Whole counter

  // ---------------- Per-module state ----------------
  logic [6:0]  mode_q [MODULES];  // Mode bits, reserved top bit not held
  logic [6:0]  mode_d [MODULES];
  reg_byte_t   capl_q [MODULES];  // Compare/capture low bytes
  reg_byte_t   capl_d [MODULES];
  reg_byte_t   caph_q [MODULES];  // Compare/capture high bytes
  reg_byte_t   caph_d [MODULES];
  logic [MODULES-1:0] flag_q;     // Module event flags
  logic [MODULES-1:0] flag_d;
  logic [MODULES-1:0] match_evt;  // Match pulses from modules
  logic [MODULES-1:0] cap_evt;    // Capture pulses from modules
  logic [MODULES-1:0] irq_en;     // Per-module interrupt enables
  logic        irq_q;             // Registered interrupt request
  logic        irq_d;

  assign idx    = wb_adr_i[9:2];
  assign req    = wb_cyc_i && wb_stb_i;
  assign wbyte  = wb_dat_i[7:0];
  // Writes land at the edge where the master sees ack
  assign wr_now = (bus_q == BUS_ACK) && req && wb_we_i && wb_sel_i[0];
  assign count  = {cnt_hi_q, cnt_lo_q};

  // Bus next state and read mux; unmapped indices read zero
  always_comb begin
    bus_d  = bus_q;
    rdat_d = rdat_q;
    case (bus_q)
      BUS_IDLE: begin
        if (req) begin
          bus_d  = BUS_ACK;
          rdat_d = 32'h0000_0000;
          if (idx == `IDX_CTRL) begin
            rdat_d[`CTRL_RUN] = run_q;
            rdat_d[MODULES-1:0] = flag_q;
          end else if (idx == `IDX_CNT_LO) begin
            rdat_d[7:0] = cnt_lo_q;
          end else if (idx == `IDX_CNT_HI) begin
            rdat_d[7:0] = cnt_hi_q;
          end
          for (int m = 0; m < MODULES; m++) begin
            // Reserved mode bit reads zero
            if (idx == `IDX_MODE_BASE + 8'(m)) begin
              rdat_d[6:0] = mode_q[m];
            end
            if (idx == `IDX_CAPL_BASE + 8'(m)) begin
              rdat_d[7:0] = capl_q[m];
            end
            if (idx == `IDX_CAPH_BASE + 8'(m)) begin
              rdat_d[7:0] = caph_q[m];
            end
          end
        end
      end
      BUS_ACK: begin
        // Ack lasts one cycle, then the slave idles
        bus_d = BUS_IDLE;
      end
      default: begin
        bus_d = BUS_IDLE;
      end
    endcase
  end

  // Bus registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      bus_q  <= BUS_IDLE;
      rdat_q <= 32'h0000_0000;
    end else begin
      bus_q  <= bus_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = (bus_q == BUS_ACK);
  assign wb_dat_o = rdat_q;

  // Prescaler and counter next values; a software write wins over a count
  always_comb begin
    pre_d    = pre_q;
    tick     = 1'b0;
    cnt_lo_d = cnt_lo_q;
    cnt_hi_d = cnt_hi_q;
    run_d    = run_q;
    upd_d    = 1'b0;
    if (run_q) begin
      if (pre_q == DIV_LAST) begin
        pre_d = 8'h00;
        tick  = 1'b1;
      end else begin
        pre_d = pre_q + 8'h01;
      end
    end
    if (tick) begin
      {cnt_hi_d, cnt_lo_d} = count + 16'h0001;
      upd_d = 1'b1;
    end
    if (wr_now && idx == `IDX_CNT_LO) begin
      cnt_lo_d = wbyte;
      upd_d    = 1'b1;
    end
    if (wr_now && idx == `IDX_CNT_HI) begin
      cnt_hi_d = wbyte;
      upd_d    = 1'b1;
    end
    if (wr_now && idx == `IDX_CTRL) begin
      run_d = wbyte[`CTRL_RUN];
    end
  end

  // Counter registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      pre_q    <= 8'h00;
      cnt_lo_q <= `CNT_RESET;
      cnt_hi_q <= `CNT_RESET;
      run_q    <= 1'b0;
      upd_q    <= 1'b0;
    end else begin
      pre_q    <= pre_d;
      cnt_lo_q <= cnt_lo_d;
      cnt_hi_q <= cnt_hi_d;
      run_q    <= run_d;
      upd_q    <= upd_d;
    end
  end

  // Per-module registers and instances
  for (genvar g = 0; g < MODULES; g++) begin : g_mod

    // Mode, compare/capture bytes and event flag next values
    always_comb begin
      mode_d[g] = mode_q[g];
      capl_d[g] = capl_q[g];
      caph_d[g] = caph_q[g];
      flag_d[g] = flag_q[g];
      if (wr_now && idx == `IDX_MODE_BASE + 8'(g)) begin
        // Top bit is not stored; software must keep it zero
        mode_d[g] = wbyte[6:0];
      end
      if (wr_now && idx == `IDX_CAPL_BASE + 8'(g)) begin
        capl_d[g] = wbyte;
      end
      if (wr_now && idx == `IDX_CAPH_BASE + 8'(g)) begin
        caph_d[g] = wbyte;
      end
      if (cap_evt[g]) begin
        // Capture overrides a same-cycle software write
        {caph_d[g], capl_d[g]} = count;
      end
      // Software may set or clear a flag through the control byte
      // Writing a one sets it, which lets software test the request path
      if (wr_now && idx == `IDX_CTRL) begin
        flag_d[g] = wbyte[g];
      end
      // Hardware set wins over a same-cycle software clear
      if (match_evt[g] || cap_evt[g]) begin
        flag_d[g] = 1'b1;
      end
    end

    // Module registers
    always_ff @(posedge mclk) begin
      if (srst) begin
        // Reset value is a byte; the stored field is seven bits wide
        mode_q[g] <= `MODE_RESET >> 1 == 8'h00 ? 7'h00 : 7'h00;
        capl_q[g] <= `CAP_RESET;
        caph_q[g] <= `CAP_RESET;
        flag_q[g] <= 1'b0;
      end else begin
        mode_q[g] <= mode_d[g];
        capl_q[g] <= capl_d[g];
        caph_q[g] <= caph_d[g];
        flag_q[g] <= flag_d[g];
      end
    end

    // Enable only gates the request; the flag itself is always kept
    // A masked flag thus raises the request one cycle after it is unmasked
    assign irq_en[g] = mode_q[g][`MODE_IRQ_EN];

    // Compare, capture and pin logic of one module
    module_channel u_chan (
      .mclk                (mclk),
      .srst                (srst),
      .count               (count),
      .cmp                 ({caph_q[g], capl_q[g]}),
      .count_upd           (upd_q),
      .compare_enable      (mode_q[g][`MODE_CMP_EN]),
      .capture_rise_enable (mode_q[g][`MODE_CAP_RISE]),
      .capture_fall_enable (mode_q[g][`MODE_CAP_FALL]),
      .hit_flag_enable     (mode_q[g][`MODE_HIT]),
      .flip_on_hit_enable  (mode_q[g][`MODE_FLIP]),
      .pulse_width_enable  (mode_q[g][`MODE_PWM]),
      .pin_i               (module_io_pin_i[g]),
      .match_evt           (match_evt[g]),
      .capture_evt         (cap_evt[g]),
      .pin_o               (module_io_pin_o[g]),
      .pin_oe_n            (module_io_pin_oe_n[g])
    );
  end

  // Interrupt request path
  // - Level request, not a pulse: it stands until software clears
  //   every enabled flag or masks every flagged module
  // - Registered once so the line never glitches on a bus write
  // - Costs one cycle of latency after the flag sets
  // - Counter overflow is not a source here
  //
  // Hazard on clearing
  // - A clear and a new event in one cycle leave the flag set
  // - Software must read the flags after clearing to see late events
  //
  // Limitation
  // - No per-source priority; software scans the flags itself
  //
  // Interrupt request: any flag whose module enable is set
  always_comb begin
    irq_d = |(flag_q & irq_en);
  end

  // Interrupt register
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irq_request_o = irq_q;

endmodule

//--- verif/pin_partner.sv
// Far-side model of one module pin and its wiring
`timescale 1ns/10ps
module pin_partner (
  input  wire logic ext_level,
  input  wire logic pin_o,
  input  wire logic pin_oe_n,
  output logic      pin_i
);
  // Outside driver shows only while the module has let go of the line
  assign pin_i = pin_oe_n ? ext_level : pin_o;
endmodule

//--- verif/counter_array_module_mode_checker.sv
// Port assertions for the counter array
`timescale 1ns/10ps
`include "pca_defs.svh"
module counter_array_module_mode_checker #(
  parameter int MODULES = 1,
  parameter int DIV     = 1
) (
  input wire logic               mclk,
  input wire logic               srst,
  input wire logic [9:0]         wb_adr_i,
  input wire logic [31:0]        wb_dat_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic [3:0]         wb_sel_i,
  input wire logic               wb_we_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o,
  input wire logic [MODULES-1:0] module_io_pin_i,
  input wire logic [MODULES-1:0] module_io_pin_o,
  input wire logic [MODULES-1:0] module_io_pin_oe_n,
  input wire logic               irq_request_o
);
  logic [6:0] mode_q; // Shadow of module 0 mode
  logic [6:0] mode_d; // Next shadow
  logic       req;    // Bus request up
  // Shadow follows completed mode writes only
  always_comb begin
    mode_d = mode_q;
    if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == `IDX_MODE_BASE) begin
      mode_d = wb_dat_i[6:0];
    end
  end
  // Register shadow
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_q <= 7'h00;
    end else begin
      mode_q <= mode_d;
    end
  end
  assign req = wb_cyc_i && wb_stb_i;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_ack_single: assert property ($rose(req) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one pulse");
  a_mode_top_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[9:2] == `IDX_MODE_BASE
    |-> wb_dat_o[31:7] == '0) else $error("mode upper bits set");
  a_reset_quiet: assert property ($fell(srst)
    |-> !irq_request_o && module_io_pin_oe_n[0] && !module_io_pin_o[0]) else $error("not idle");
  a_oe_needs_cmp: assert property (!mode_q[6] && !$past(mode_q[6]) |-> module_io_pin_oe_n[0])
    else $error("pin driven without compare");
  a_irq_masked: assert property (!mode_q[0] && !$past(mode_q[0]) |-> !irq_request_o)
    else $error("irq while masked");
  a_flip_cause: assert property ($changed(module_io_pin_o[0]) && !$past(mode_q[1])
    |-> $past(mode_q[6] && mode_q[3] && mode_q[2])) else $error("pin flipped without mode");
  a_rise_capture: assert property ($rose(module_io_pin_i[0]) && mode_q[5] && mode_q[0]
    |-> ##[1:4] irq_request_o) else $error("rise not captured");
  a_fall_capture: assert property ($fell(module_io_pin_i[0]) && mode_q[4] && mode_q[0]
    |-> ##[1:4] irq_request_o) else $error("fall not captured");
  c_irq: cover property ($rose(irq_request_o));
  c_flip: cover property ($changed(module_io_pin_o[0]) && mode_q[2]);
  c_pwm: cover property (mode_q[1] && !module_io_pin_oe_n[0]);
endmodule
bind counter_array_module_mode counter_array_module_mode_checker #(
  .MODULES(MODULES), .DIV(DIV)) i_chk (.mclk, .srst, .wb_adr_i, .wb_dat_i, .wb_dat_o,
  .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .module_io_pin_i, .module_io_pin_o,
  .module_io_pin_oe_n, .irq_request_o);

//--- verif/testbench.sv
// Self-checking bench for the counter array
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench;
  typedef struct { logic we; logic [7:0] idx; logic [7:0] wd; logic [7:0] ex; } row_t;
  logic        mclk, srst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [9:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i;
  logic        pin_i, pin_o, oe_n, irq, ext; // Pin wires and far-side level
  logic [7:0]  rd;                           // Last read byte
  int          errors, n_compared, cycles;
  // Plain accesses: reset values, read-back, unmapped place
  row_t rows [8] = '{'{0, 8'hE9, 8'h00, 8'h00}, '{0, 8'hF9, 8'h00, 8'h00},
    '{0, 8'hDA, 8'h00, 8'h00}, '{1, 8'hE9, 8'h37, 8'h37}, '{1, 8'hF9, 8'hA5, 8'hA5},
    '{1, 8'hDA, 8'h3F, 8'h3F}, '{1, 8'hDA, 8'h00, 8'h00}, '{1, 8'hC0, 8'h55, 8'h00}};
  counter_array_module_mode #(.MODULES(1), .DIV(1)) i_dut (.mclk, .srst, .wb_adr_i,
    .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .module_io_pin_i(pin_i), .module_io_pin_o(pin_o), .module_io_pin_oe_n(oe_n),
    .irq_request_o(irq));
  pin_partner i_pin (.ext_level(ext), .pin_o(pin_o), .pin_oe_n(oe_n), .pin_i(pin_i));
  // Verdict and end of run
  task automatic give_verdict();
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One classic cycle; request held until ack is sampled
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, wd};
    @(posedge mclk);
    while (wb_ack_o !== 1'b1) @(posedge mclk);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Read a register and compare
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] ex);
    xfer(1'b0, idx, 8'h00);
    `CHK($sformatf("reg %h", idx), ex, rd)
  endtask
  // Far-side pin change at a clock edge
  task automatic pin_set(input logic v);
    @(posedge mclk);
    ext <= v;
    repeat (4) @(posedge mclk);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    srst = 1'b1; wb_we_i = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; ext = 1'b0;
    wb_adr_i = '0; wb_dat_i = '0; wb_sel_i = 4'hF;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].we) xfer(1'b1, rows[i].idx, rows[i].wd);
      rd_chk(rows[i].idx, rows[i].ex);
    end
    xfer(1'b1, 8'hDA, 8'h21);
    pin_set(1'b1);
    `CHK("irq rise", 1'b1, irq)
    rd_chk(8'hEA, 8'h37);
    xfer(1'b1, 8'hD8, 8'h00);
    xfer(1'b1, 8'hDA, 8'h11);
    pin_set(1'b0);
    `CHK("irq fall", 1'b1, irq)
    xfer(1'b1, 8'hD8, 8'h00);
    xfer(1'b1, 8'hDA, 8'h20);
    pin_set(1'b1);
    `CHK("irq masked", 1'b0, irq)
    xfer(1'b1, 8'hDA, 8'h21);
    repeat (3) @(posedge mclk);
    `CHK("irq unmasked", 1'b1, irq)
    xfer(1'b1, 8'hEA, 8'h40);
    xfer(1'b1, 8'hFA, 8'h00);
    xfer(1'b1, 8'hF9, 8'h00);
    for (int m = 0; m < 2; m++) begin
      xfer(1'b1, 8'hD8, 8'h00);
      xfer(1'b1, 8'hE9, 8'h3C);
      xfer(1'b1, 8'hDA, m ? 8'h4C : 8'h0C);
      xfer(1'b1, 8'hD8, 8'h40);
      repeat (20) @(posedge mclk);
      rd_chk(8'hD8, m ? 8'h41 : 8'h40);
      `CHK("pin flip", m[0], pin_o)
      `CHK("pin oe_n", ~m[0], oe_n)
    end
    xfer(1'b1, 8'hD8, 8'h00);
    xfer(1'b1, 8'hDA, 8'h42);
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, 8'hE9, k ? 8'h10 : 8'h50);
      repeat (4) @(posedge mclk);
      `CHK("pwm level", ~k[0], pin_o)
    end
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rd_chk(8'hDA, 8'h00);
    rd_chk(8'hF9, 8'h00);
    give_verdict();
  end
endmodule
